// file: src/pst_safety.v
/*
 * Second-level safety monitor and charge-current throttle.
 * Assumes measurements and configuration from same-clock logic, a one-cycle
 * measurement tick, and asynchronous pins for watchdog and failure input.
 */
// How it works
// R1 - front-end clock out of range sets fault; in range and verified clears
// R2 - host watchdog fault after configured idle time; clears on traffic
// R3 - cell overvoltage threshold optionally shifted by temperature
// R4 - external fail input low for configured time raises failure
// R5 - pack voltage at or above safety threshold for time fails
// R6 - charge and discharge overcurrent failures, each own threshold and time
// R7 - charge over-temperature failure after persistence
// R8 - discharge over-temperature failure, compared against temperature
// R9 - cell max minus min at or above threshold for time fails
// R10 - charge and precharge fets off with current flowing fails
// R11 - discharge fet off with current flowing fails
// R12 - bad front-end communications counted; failure at limit
// R13 - periodic front-end check failures counted; failure at limit
// R14 - configuration checksum mismatch raises storage failure
// R15 - top temperature band requests precharge current
// R16 - second band requests half of fast minus precharge current
// R17 - lower band below the second band requests fast current; precharge_temp is not compared
// R18 - zero temperature step disables throttling
// R19 - throttle flag set whenever a temperature band reduced requested current
// R20 - separate precharge and fast-charge timeouts reported in status
// R21 - configuration addressed by class identifier plus subclass offset
// R22 - persistence timers restart when condition drops early
// R23 - failures stay latched until keyed clear sequence
`timescale 1ns/1ps
`include "pst_map.vh"

module pst_safety #(
    parameter DW  = 16,
    parameter TW  = 16,
    parameter CW  = 8,
    parameter WDW = 8
) (
    input  wire          clk,
    input  wire          rst_b,
    input  wire          tick,
    input  wire          frontend_watchdog_input,
    input  wire          external_fail_input,
    input  wire [WDW-1:0] wd_min,
    input  wire [WDW-1:0] wd_max,
    input  wire          frontend_verify_ok,
    input  wire          smbus_activity,
    input  wire [TW-1:0] host_watchdog_time,
    input  wire [DW-1:0] cov_base,
    input  wire [DW-1:0] cov_temp_delta,
    input  wire [DW-1:0] cov_temp_limit,
    input  wire          cov_temp_comp_en,
    input  wire [DW-1:0] pack_voltage,
    input  wire [DW-1:0] chg_current,
    input  wire [DW-1:0] dsg_current,
    input  wire [DW-1:0] temperature,
    input  wire [DW-1:0] cell_max,
    input  wire [DW-1:0] cell_min,
    input  wire          chg_fet_on,
    input  wire          precharge_fet,
    input  wire          dsg_fet_on,
    input  wire [DW-1:0] sov_thr,
    input  wire [DW-1:0] socc_thr,
    input  wire [DW-1:0] socd_thr,
    input  wire [DW-1:0] sotc_thr,
    input  wire [DW-1:0] sotd_thr,
    input  wire [DW-1:0] imb_thr,
    input  wire [DW-1:0] fet_thr,
    input  wire [TW-1:0] ext_time,
    input  wire [TW-1:0] sov_time,
    input  wire [TW-1:0] socc_time,
    input  wire [TW-1:0] socd_time,
    input  wire [TW-1:0] sotc_time,
    input  wire [TW-1:0] sotd_time,
    input  wire [TW-1:0] imb_time,
    input  wire [TW-1:0] fet_time,
    input  wire          comm_bad,
    input  wire          periodic_bad,
    input  wire [CW-1:0] fail_limit,
    input  wire          csum_valid,
    input  wire [DW-1:0] csum_computed,
    input  wire [DW-1:0] stored_config_checksum,
    input  wire          clear_valid,
    input  wire [DW-1:0] clear_word,
    input  wire [1:0]    charge_mode,
    input  wire [DW-1:0] charge_suspend_temp_high,
    input  wire [DW-1:0] throttle_temperature_step,
    input  wire [DW-1:0] precharge_temp,
    input  wire [DW-1:0] fast_current,
    input  wire [DW-1:0] pre_current,
    input  wire [TW-1:0] pre_timeout,
    input  wire [TW-1:0] fast_timeout,
    input  wire [7:0]    cfg_class,
    input  wire [7:0]    cfg_offset,
    output reg  [15:0]   cfg_addr,
    output reg           frontend_wd_fault,
    output reg           host_wd_fault,
    output reg  [DW-1:0] cov_threshold,
    output reg  [`PST_NFAULT-1:0] fail_latched,
    output reg           perm_fail,
    output reg  [DW-1:0] charging_current,
    output reg  [`PST_CS_W-1:0] charging_status,
    output reg  [CW-1:0] comm_fail_count,
    output reg  [CW-1:0] periodic_fail_count
);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [1:0] wdi_s;
reg [1:0] external_fail_input_s;
reg       wdi_d;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wdi_s  <= 2'h0;
        external_fail_input_s <= 2'h3;
        wdi_d  <= 1'b0;
    end else begin
        wdi_s  <= {wdi_s[0], frontend_watchdog_input};
        external_fail_input_s <= {external_fail_input_s[0], external_fail_input};
        wdi_d  <= wdi_s[1];
    end
end

////////////////////////////////////////////////////////////////////////////
// front-end clock period check
reg [WDW-1:0] wd_cnt;
reg           wd_bad;
reg           wd_seen;
wire          wd_edge = wdi_s[1] & ~wdi_d;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wd_cnt  <= {WDW{1'b0}};
        wd_bad  <= 1'b0;
        wd_seen <= 1'b0;
    end else if (wd_edge) begin
        wd_cnt  <= {WDW{1'b0}};
        wd_seen <= 1'b1;
        // first edge after reset only starts a measurement
        wd_bad  <= wd_seen & ((wd_cnt < wd_min) | (wd_cnt > wd_max));
    end else if (wd_cnt == wd_max) begin
        wd_bad <= 1'b1;
    end else begin
        wd_cnt <= wd_cnt + 1'b1;
    end
end

// R1 watchdog fault latch
always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
        frontend_wd_fault <= 1'b0;
    else if (wd_bad)
        frontend_wd_fault <= 1'b1;
    else if (frontend_verify_ok)
        frontend_wd_fault <= 1'b0;
end

// R2 host idle timer
reg [TW-1:0] host_cnt;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        host_cnt      <= {TW{1'b0}};
        host_wd_fault <= 1'b0;
    end else if (smbus_activity) begin
        host_cnt      <= {TW{1'b0}};
        host_wd_fault <= 1'b0;
    end else if (tick) begin
        if (host_cnt >= host_watchdog_time)
            host_wd_fault <= 1'b1;
        else
            host_cnt <= host_cnt + 1'b1;
    end
end

// R3 temperature compensated threshold
// R21 class and offset address
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cov_threshold <= {DW{1'b0}};
        cfg_addr      <= 16'h0000;
    end else begin
        cfg_addr <= {cfg_class, cfg_offset};
        if (cov_temp_comp_en && temperature >= cov_temp_limit)
            cov_threshold <= cov_base - cov_temp_delta;
        else
            cov_threshold <= cov_base;
    end
end

////////////////////////////////////////////////////////////////////////////
// persistence conditions
wire [DW-1:0] imb_diff = cell_max - cell_min;
wire [8:0] cond;
wire [TW*9-1:0] ptime;
// R4 R5 R6 R7 R8 R9 R10 R11 qualifying conditions
assign cond[0] = ~external_fail_input_s[1];
assign cond[1] = pack_voltage >= sov_thr;
assign cond[2] = chg_current >= socc_thr;
assign cond[3] = dsg_current >= socd_thr;
assign cond[4] = temperature >= sotc_thr;
assign cond[5] = temperature >= sotd_thr;
assign cond[6] = (cell_max >= cell_min) && (imb_diff >= imb_thr);
assign cond[7] = ~chg_fet_on & ~precharge_fet & (chg_current >= fet_thr);
assign cond[8] = ~dsg_fet_on & (dsg_current >= fet_thr);
assign ptime = {fet_time, fet_time, imb_time, sotd_time, sotc_time,
                socd_time, socc_time, sov_time, ext_time};

wire clear_ok;
reg  [8:0] hit;
genvar g;
generate
    for (g = 0; g < 9; g = g + 1) begin : pers
        reg [TW-1:0] cnt;
        // R22 restart on drop
        always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                cnt    <= {TW{1'b0}};
                hit[g] <= 1'b0;
            end else if (!cond[g]) begin
                cnt    <= {TW{1'b0}};
                hit[g] <= 1'b0;
            end else if (tick) begin
                if (cnt + 1'b1 >= ptime[g*TW +: TW])
                    hit[g] <= 1'b1;
                else
                    cnt <= cnt + 1'b1;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// R12 R13 front-end fail counters
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        comm_fail_count     <= {CW{1'b0}};
        periodic_fail_count <= {CW{1'b0}};
    end else if (clear_ok) begin
        comm_fail_count     <= {CW{1'b0}};
        periodic_fail_count <= {CW{1'b0}};
    end else begin
        if (comm_bad && comm_fail_count != {CW{1'b1}})
            comm_fail_count <= comm_fail_count + 1'b1;
        if (periodic_bad && periodic_fail_count != {CW{1'b1}})
            periodic_fail_count <= periodic_fail_count + 1'b1;
    end
end

// R23 two-word clear key
reg key_armed;
assign clear_ok = clear_valid & key_armed & (clear_word == `PST_CLR_KEY2);
always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
        key_armed <= 1'b0;
    else if (clear_valid)
        key_armed <= (clear_word == `PST_CLR_KEY1);
end

// R14 checksum mismatch
wire csum_bad = csum_valid & (csum_computed != stored_config_checksum);
wire [`PST_NFAULT-1:0] raise = {csum_bad,
    periodic_bad & (periodic_fail_count >= fail_limit),
    comm_bad & (comm_fail_count >= fail_limit), hit};

// R23 latched until keyed clear, set wins
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        fail_latched <= {`PST_NFAULT{1'b0}};
        perm_fail    <= 1'b0;
    end else begin
        fail_latched <= (clear_ok ? {`PST_NFAULT{1'b0}} : fail_latched)
                        | raise;
        perm_fail    <= (clear_ok ? 1'b0 : perm_fail) | (|raise);
    end
end

////////////////////////////////////////////////////////////////////////////
// charge current throttle
wire [DW:0] lim1 = {1'b0, charge_suspend_temp_high}
                   - {1'b0, throttle_temperature_step};
wire [DW:0] lim2 = lim1 - {1'b0, throttle_temperature_step};
wire [DW:0] t_x  = {1'b0, temperature};
wire        fast = charge_mode == `PST_MODE_FAST;
wire        step0 = throttle_temperature_step == {DW{1'b0}};
wire        below = temperature < charge_suspend_temp_high;
reg  [DW-1:0] next_current;
reg           next_throttle;
always @* begin
    next_current  = fast_current;
    next_throttle = 1'b0;
    // R18 zero step disables
    if (fast && !step0 && below) begin
        // R15 top band
        if (!lim1[DW] && t_x >= lim1) begin
            next_current  = pre_current;
            next_throttle = 1'b1;
        // R16 middle band
        end else if (!lim2[DW] && t_x >= lim2) begin
            next_current  = (fast_current - pre_current) >> 1;
            next_throttle = 1'b1;
        end
        // R17 full fast current below middle band; precharge_temp not compared
    end
    if (charge_mode == `PST_MODE_PRE)
        next_current = pre_current;
end

// R20 separate mode timeouts
reg [TW-1:0] chg_timer;
reg [1:0]    mode_d;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        chg_timer        <= {TW{1'b0}};
        mode_d           <= `PST_MODE_IDLE;
        charging_current <= {DW{1'b0}};
        charging_status  <= {`PST_CS_W{1'b0}};
    end else begin
        mode_d           <= charge_mode;
        charging_current <= next_current;
        // R19 throttle flag
        charging_status[`PST_CS_CHARGE_THROTTLE_FLAG] <= next_throttle;
        if (charge_mode != mode_d) begin
            chg_timer <= {TW{1'b0}};
            charging_status[`PST_CS_PTO] <= 1'b0;
            charging_status[`PST_CS_FTO] <= 1'b0;
        end else if (tick) begin
            if (chg_timer != {TW{1'b1}})
                chg_timer <= chg_timer + 1'b1;
            if (charge_mode == `PST_MODE_PRE && pre_timeout != {TW{1'b0}}
                && chg_timer >= pre_timeout)
                charging_status[`PST_CS_PTO] <= 1'b1;
            if (fast && fast_timeout != {TW{1'b0}}
                && chg_timer >= fast_timeout)
                charging_status[`PST_CS_FTO] <= 1'b1;
        end
    end
end

endmodule

// file: src/pst_map.vh
/*
 * Constants for the pack safety and charge throttle block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PST_MAP_VH
`define PST_MAP_VH

// fault vector bit positions
`define PST_F_EXT      0
`define PST_F_SOV      1
`define PST_F_SOCC     2
`define PST_F_SOCD     3
`define PST_F_SOTC     4
`define PST_F_SOTD     5
`define PST_F_IMB      6
`define PST_F_CFET     7
`define PST_F_DFET     8
`define PST_F_COMM     9
`define PST_F_PER      10
`define PST_F_CSUM     11
`define PST_NFAULT     12

// charging status word bits
`define PST_CS_CHARGE_THROTTLE_FLAG    0
`define PST_CS_PTO     1
`define PST_CS_FTO     2
`define PST_CS_W       3

// charge modes
`define PST_MODE_IDLE  2'h0
`define PST_MODE_PRE   2'h1
`define PST_MODE_FAST  2'h2

// clear key for latched failures
`define PST_CLR_KEY1   16'h2673
`define PST_CLR_KEY2   16'h1712

`endif

// file: verif/pst_safety_chk.sv
/* Port assertions for the safety and throttle block.
   Assumes a bind onto the block and its header constants. */
`timescale 1ns/1ps
`include "pst_map.vh"
module pst_safety_chk #(
    parameter DW = 16,
    parameter CW = 8
) (
    input wire                   clk,
    input wire                   rst_b,
    input wire [7:0]             cfg_class,
    input wire [7:0]             cfg_offset,
    input wire [15:0]            cfg_addr,
    input wire [`PST_NFAULT-1:0] fail_latched,
    input wire                   perm_fail,
    input wire                   clear_valid,
    input wire [1:0]             charge_mode,
    input wire [DW-1:0]          charge_suspend_temp_high,
    input wire [DW-1:0]          throttle_temperature_step,
    input wire [DW-1:0]          temperature,
    input wire [DW-1:0]          fast_current,
    input wire [DW-1:0]          pre_current,
    input wire [DW-1:0]          charging_current,
    input wire [`PST_CS_W-1:0]   charging_status,
    input wire                   comm_bad,
    input wire [CW-1:0]          comm_fail_count,
    input wire [CW-1:0]          fail_limit,
    input wire                   csum_valid,
    input wire [DW-1:0]          csum_computed,
    input wire [DW-1:0]          stored_config_checksum
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
wire          fast_md = charge_mode == `PST_MODE_FAST;
wire          step_on = throttle_temperature_step != 0;
wire [DW-1:0] lo1     = charge_suspend_temp_high - throttle_temperature_step;
wire [DW-1:0] lo2     = lo1 - throttle_temperature_step;
wire          ok_lo   = lo2 <= lo1 && lo1 <= charge_suspend_temp_high;
wire          band1   = fast_md && step_on && ok_lo &&
                        temperature < charge_suspend_temp_high &&
                        temperature >= lo1;
wire          band2   = fast_md && step_on && ok_lo &&
                        temperature < lo1 && temperature >= lo2;
addr_capture_a: assert property (
    $past(rst_b, 2) |-> cfg_addr == {$past(cfg_class), $past(cfg_offset)})
    else $error("config address mismatch");
latch_hold_a: assert property (
    !$past(clear_valid) |->
    (fail_latched & $past(fail_latched)) == $past(fail_latched))
    else $error("failure bit dropped without clear");
perm_follow_a: assert property (
    |fail_latched |-> ##[0:1] perm_fail)
    else $error("permanent failure not raised");
throttle_off_a: assert property (
    $past(rst_b, 2) && $past(fast_md && !step_on) |->
    charging_current == $past(fast_current) && !charging_status[0])
    else $error("throttle active with zero step");
top_band_a: assert property (
    $past(rst_b, 2) && $past(band1) |->
    charging_current == $past(pre_current))
    else $error("top band current wrong");
mid_band_a: assert property (
    $past(rst_b, 2) && $past(band2) |->
    charging_current == ($past(fast_current) - $past(pre_current)) >> 1)
    else $error("middle band current wrong");
comm_limit_a: assert property (
    comm_bad && !fail_latched[`PST_F_COMM] |=>
    fail_latched[`PST_F_COMM] == ($past(comm_fail_count) >= $past(fail_limit)))
    else $error("comm failure limit wrong");
csum_check_a: assert property (
    csum_valid && !fail_latched[`PST_F_CSUM] |=> fail_latched[`PST_F_CSUM]
    == ($past(csum_computed) != $past(stored_config_checksum)))
    else $error("checksum failure wrong");
endmodule
bind pst_safety pst_safety_chk #(.DW(DW), .CW(CW)) u_chk (.*);

// file: verif/pst_far_model.sv
/* Far side: front-end clock output and host bus traffic.
   Assumes the bench sets the half period; zero stops the clock. */
`timescale 1ns/1ps
module pst_far_model (
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] half,
    input  wire       talk,
    output reg        frontend_watchdog_input,
    output reg        smbus_activity
);
reg [7:0] cnt;
wire      wrap = cnt + 8'h01 >= half;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cnt <= 8'h00;
        frontend_watchdog_input <= 1'b0;
        smbus_activity <= 1'b0;
    end else begin
        cnt <= wrap ? 8'h00 : cnt + 8'h01;
        if (half != 8'h00 && wrap)
            frontend_watchdog_input <= ~frontend_watchdog_input;
        smbus_activity <= talk && cnt == 8'h00;
    end
end
endmodule

// file: verif/tb_top.sv
/* Self-checking bench for the safety and throttle block.
   Assumes the far-side model and the bound checker. */
`timescale 1ns/1ps
`include "pst_map.vh"
module tb_top;
logic clk = 0, rst_b = 0, tick = 0, go = 0, talk = 1;
logic frontend_watchdog_input, smbus_activity, external_fail_input;
logic frontend_verify_ok, cov_temp_comp_en, chg_fet_on, precharge_fet;
logic dsg_fet_on, comm_bad, periodic_bad, csum_valid, clear_valid;
logic frontend_wd_fault, host_wd_fault, perm_fail;
logic [1:0] charge_mode, tc = 0;
logic [2:0] charging_status;
logic [7:0] wd_min, wd_max, fail_limit, cfg_class, cfg_offset, half;
logic [7:0] comm_fail_count, periodic_fail_count;
logic [11:0] fail_latched;
logic [15:0] host_watchdog_time, cov_base, cov_temp_delta, cov_temp_limit;
logic [15:0] pack_voltage, chg_current, dsg_current, temperature, cell_max;
logic [15:0] cell_min, sov_thr, socc_thr, socd_thr, sotc_thr, sotd_thr;
logic [15:0] imb_thr, fet_thr, ext_time, sov_time, socc_time, socd_time;
logic [15:0] sotc_time, sotd_time, imb_time, fet_time, csum_computed;
logic [15:0] stored_config_checksum, clear_word, charge_suspend_temp_high;
logic [15:0] throttle_temperature_step, precharge_temp, fast_current;
logic [15:0] pre_current, pre_timeout, fast_timeout, cfg_addr, v;
logic [15:0] cov_threshold, charging_current;
integer seed = 32'heccfd894, err_total = 0, num_checks = 0, k, j;
int qs[$];
logic [31:0] qv[$];
string nm[10] = '{"fail", "icur", "tmo", "addr", "fewd", "hwd", "cnt",
                  "perm", "cov", "charge_throttle_flag"};
pst_safety dut (.*);
pst_far_model far (.*);
always #12.5 clk = ~clk;
always @(posedge clk) begin
    tc <= tc + 2'h1;
    tick <= tc == 2'h3;
end
function automatic logic [31:0] obs(int s);
    case (s)
        0: obs = fail_latched;
        1: obs = charging_current;
        2: obs = charging_status[`PST_CS_FTO:`PST_CS_PTO];
        3: obs = cfg_addr;
        4: obs = frontend_wd_fault;
        5: obs = host_wd_fault;
        6: obs = {periodic_fail_count, comm_fail_count};
        7: obs = perm_fail;
        8: obs = cov_threshold;
        default: obs = charging_status[`PST_CS_CHARGE_THROTTLE_FLAG];
    endcase
endfunction
always @(posedge clk) if (go) begin
    num_checks++;
    if (obs(qs[0]) !== qv[0]) begin
        err_total++;
        $display("[FAIL] %s exp %h got %h", nm[qs[0]], qv[0], obs(qs[0]));
    end
    void'(qs.pop_front());
    void'(qv.pop_front());
end
task cyc(int n);
    repeat (n) @(posedge clk);
endtask
task ex(int s, logic [31:0] e);
    qs.push_back(s);
    qv.push_back(e);
    go <= 1;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
endtask
task cl(logic [15:0] w);
    clear_valid <= 1;
    clear_word <= w;
    @(posedge clk);
    clear_valid <= 0;
    cyc(2);
endtask
task clr;
    cl(`PST_CLR_KEY1);
    cl(`PST_CLR_KEY2);
endtask
task pb(int n);
    comm_bad <= n == 0;
    periodic_bad <= n == 1;
    @(posedge clk);
    comm_bad <= 0;
    periodic_bad <= 0;
    @(posedge clk);
endtask
task arm(int n);
    sov_thr <= n == 1 ? 16'd500 : 16'hffff;
    socc_thr <= n == 2 ? 16'd500 : 16'hffff;
    socd_thr <= n == 3 ? 16'd500 : 16'hffff;
    sotc_thr <= n == 4 ? 16'd500 : 16'hffff;
    sotd_thr <= n == 5 ? 16'd500 : 16'hffff;
    imb_thr <= n == 6 ? 16'd500 : 16'hffff;
    chg_fet_on <= n != 7;
    precharge_fet <= n != 7;
    dsg_fet_on <= n != 8;
endtask
task summarize;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize;
end
initial begin
    {external_fail_input, frontend_verify_ok, chg_fet_on} = 3'h7;
    {precharge_fet, dsg_fet_on, cov_temp_comp_en, comm_bad} = 4'hc;
    {periodic_bad, csum_valid, clear_valid, charge_mode} = 5'h00;
    {wd_min, wd_max, half, fail_limit} = 32'h080c0503;
    {cfg_class, cfg_offset, host_watchdog_time} = 32'h00000005;
    {sov_thr, socc_thr, socd_thr, sotc_thr, sotd_thr} = {5{16'hffff}};
    {imb_thr, fet_thr} = 32'hffff01f4;
    {ext_time, sov_time, socc_time, socd_time} = {4{16'h0003}};
    {sotc_time, sotd_time, imb_time, fet_time} = {4{16'h0003}};
    {cov_base, cov_temp_delta, cov_temp_limit, pack_voltage} = '0;
    {chg_current, dsg_current, temperature, cell_max, cell_min} = '0;
    {csum_computed, stored_config_checksum, clear_word, pre_timeout} = '0;
    {charge_suspend_temp_high, throttle_temperature_step} = '0;
    {precharge_temp, fast_current, pre_current, fast_timeout} = '0;
    cyc(2);
    rst_b <= 1;
    cyc(2);
    repeat (4) begin
        cfg_class <= 8'($random(seed));
        cfg_offset <= 8'($random(seed));
        cyc(3);
        ex(3, {cfg_class, cfg_offset});
    end
    charge_mode <= `PST_MODE_FAST;
    charge_suspend_temp_high <= 16'd100;
    fast_current <= 16'd1000;
    pre_current <= 16'd200;
    for (k = 0; k < 4; k++) begin
        temperature <= k == 3 ? 16'd95 : 16'd95 - 16'd10 * k;
        throttle_temperature_step <= k == 3 ? 16'd0 : 16'd10;
        cyc(3);
        ex(1, k == 0 ? 200 : k == 1 ? 400 : 1000);
        ex(9, k < 2);
    end
    {cov_base, cov_temp_delta, cov_temp_limit} <= 48'h0fa000140032;
    for (k = 0; k < 2; k++) begin
        cov_temp_comp_en <= k;
        cyc(3);
        ex(8, 16'd4000 - 16'd20 * k);
    end
    sov_thr <= 16'd500;
    repeat (3) begin
        pack_voltage <= 16'd600;
        cyc(8);
        pack_voltage <= 16'd0;
        cyc(4);
    end
    ex(0, 0);
    {pack_voltage, chg_current, dsg_current} <= {3{16'd600}};
    {temperature, cell_max} <= {2{16'd600}};
    for (k = 1; k < 9; k++) begin
        arm(k);
        cyc(24);
        ex(0, 1 << k);
        arm(0);
        cyc(8);
        ex(0, 1 << k);
        cl(`PST_CLR_KEY2);
        ex(0, 1 << k);
        clr;
        ex(0, 0);
    end
    external_fail_input <= 0;
    cyc(24);
    external_fail_input <= 1;
    cyc(4);
    ex(0, 1);
    ex(7, 1);
    clr;
    for (j = 0; j < 2; j++) begin
        repeat (3) pb(j);
        ex(6, 3 << (8 * j));
        ex(0, 0);
        pb(j);
        ex(0, 1 << (9 + j));
        clr;
        ex(6, 0);
    end
    for (k = 0; k < 2; k++) begin
        v = 16'($random(seed));
        stored_config_checksum <= v;
        csum_computed <= v ^ k;
        csum_valid <= 1;
        @(posedge clk);
        csum_valid <= 0;
        cyc(2);
        ex(0, k << 11);
    end
    clr;
    talk <= 0;
    cyc(40);
    ex(5, 1);
    talk <= 1;
    cyc(8);
    ex(5, 0);
    half <= 8'd2;
    cyc(30);
    ex(4, 1);
    frontend_verify_ok <= 0;
    half <= 8'd5;
    cyc(40);
    ex(4, 1);
    frontend_verify_ok <= 1;
    cyc(40);
    ex(4, 0);
    charge_mode <= `PST_MODE_PRE;
    pre_timeout <= 16'd3;
    cyc(24);
    ex(2, 1);
    charge_mode <= `PST_MODE_FAST;
    fast_timeout <= 16'd3;
    cyc(24);
    ex(2, 2);
    summarize;
end
endmodule
